//--- dv/mfmw_drive_model.sv
`timescale 1ns/100ps
module mfmw_drive_model #(
	parameter int INDEX_PERIOD = 4000
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic write_gate_n,
	input wire logic write_data,
	output logic index_n
);
	int cyc;
	int rises[$];
	logic wd_q;
	// index once a revolution; the revolution is far shorter than a real one
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cyc <= 0;
			index_n <= 1'b1;
			wd_q <= 1'b0;
		end else begin
			cyc <= cyc + 1;
			index_n <= (cyc % INDEX_PERIOD) >= 8;
			wd_q <= write_data;
			// only gated flux changes reach the medium
			if (!write_gate_n && write_data && !wd_q)
				rises.push_back(cyc);
		end
	end
endmodule : mfmw_drive_model

//--- dv/mfmw_write_path_sva.sv
`timescale 1ns/100ps
module mfmw_write_path_chk (
	input wire logic CLK_SYS,
	input wire logic NRST,
	input wire logic START_WRITE,
	input wire logic START_FORMAT,
	input wire logic INDEX_N,
	input wire logic S_LAST,
	input wire logic S_VALID,
	input wire logic S_READY,
	input wire logic WRITE_GATE_N,
	input wire logic WRITE_DATA,
	input wire logic BUSY,
	input wire logic UNDERRUN,
	input wire logic FMT_OVER
);
	logic fmt_q;
	logic post_q;
	logic [9:0] cnt_q;
	wire logic take = S_VALID && S_READY;
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!NRST);
	// ----
	// helper state
	// ----
	// format mode lasts until the gate drops away again
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST)
			fmt_q <= 1'b0;
		else if (START_FORMAT)
			fmt_q <= 1'b1;
		else if ($rose(WRITE_GATE_N))
			fmt_q <= 1'b0;
	end
	// cycles since the last payload byte was taken, saturating
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			post_q <= 1'b0;
			cnt_q <= 10'h000;
		end else if (take && S_LAST && !fmt_q) begin
			post_q <= 1'b1;
			cnt_q <= 10'h000;
		end else begin
			if ($rose(WRITE_GATE_N))
				post_q <= 1'b0;
			if (cnt_q != 10'h3FF)
				cnt_q <= cnt_q + 10'h001;
		end
	end
	// ----
	// properties
	// ----
	AST_PULSE_WIDTH: assert property (
		$rose(WRITE_DATA) |-> WRITE_DATA [*4] ##1 !WRITE_DATA)
		else $error("write pulse not four cycles wide");
	AST_IDLE_QUIET: assert property (
		!BUSY |-> !WRITE_DATA && WRITE_GATE_N)
		else $error("gate or pulse while idle");
	AST_READY_IDLE: assert property (
		!BUSY |-> !S_READY)
		else $error("stream ready while idle");
	AST_READY_DROP: assert property (
		take |=> !S_READY)
		else $error("ready stayed up after a take");
	AST_WRITE_OPEN: assert property (
		START_WRITE && !START_FORMAT && !BUSY |-> ##2 !WRITE_GATE_N && BUSY)
		else $error("write gate not opened two cycles after start");
	AST_FMT_BEGIN: assert property (
		fmt_q && WRITE_GATE_N && $fell(INDEX_N) |-> ##[1:4] !WRITE_GATE_N)
		else $error("format did not open gate at index");
	AST_FMT_END: assert property (
		fmt_q && !WRITE_GATE_N && $fell(INDEX_N) |-> ##[1:4] WRITE_GATE_N)
		else $error("format did not close gate at next index");
	AST_POSTAMBLE: assert property (
		$rose(WRITE_GATE_N) && post_q |-> cnt_q >= 10'd690 && cnt_q <= 10'd900)
		else $error("gate released without the postamble span");
	AST_UNDERRUN_HOLD: assert property (
		UNDERRUN && !START_WRITE && !START_FORMAT |=> UNDERRUN)
		else $error("underrun flag dropped by itself");
	AST_OVER_HOLD: assert property (
		FMT_OVER && !START_WRITE && !START_FORMAT |=> FMT_OVER)
		else $error("format overrun flag dropped by itself");
endmodule : mfmw_write_path_chk

bind mfmw_write_path mfmw_write_path_chk i_chk (.CLK_SYS(CLK_SYS),
	.NRST(NRST), .START_WRITE(START_WRITE), .START_FORMAT(START_FORMAT),
	.INDEX_N(INDEX_N), .S_LAST(S_LAST), .S_VALID(S_VALID),
	.S_READY(S_READY), .WRITE_GATE_N(WRITE_GATE_N),
	.WRITE_DATA(WRITE_DATA), .BUSY(BUSY), .UNDERRUN(UNDERRUN),
	.FMT_OVER(FMT_OVER));

//--- dv/tb.sv
`timescale 1ns/100ps
module tb;
	localparam int PERIOD = 4000;
	localparam logic [7:0] PAYLOAD [4] = '{8'hB1, 8'h0F, 8'h6C, 8'hE5};
	logic clk_sys, nrst, start_write, start_format, adjacent, index_n;
	logic s_last, s_valid, s_ready, write_gate_n, write_data, busy;
	logic underrun, fmt_over;
	logic [9:0] cylinder;
	logic [7:0] s_data, gap3_min;
	int num_errors, num_checks;
	mfmw_write_path i_dut (.CLK_SYS(clk_sys), .NRST(nrst),
		.START_WRITE(start_write), .START_FORMAT(start_format),
		.CYLINDER(cylinder), .ADJACENT(adjacent), .INDEX_N(index_n),
		.S_DATA(s_data), .S_LAST(s_last), .S_VALID(s_valid),
		.S_READY(s_ready), .WRITE_GATE_N(write_gate_n),
		.WRITE_DATA(write_data), .BUSY(busy), .UNDERRUN(underrun),
		.FMT_OVER(fmt_over), .GAP3_MIN(gap3_min));
	mfmw_drive_model #(.INDEX_PERIOD(PERIOD)) i_drive (.clk(clk_sys),
		.nrst(nrst), .write_gate_n(write_gate_n), .write_data(write_data),
		.index_n(index_n));
	// ----
	// helpers
	// ----
	task automatic check(logic [31:0] got, logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	// holds valid up between bytes so it is never lowered and raised at once
	task automatic send(logic [7:0] b, logic last);
		int n;
		n = 0;
		s_data <= b;
		s_last <= last;
		s_valid <= 1'b1;
		@(posedge clk_sys);
		while (s_ready !== 1'b1 && n < 1000) begin
			n++;
			@(posedge clk_sys);
		end
		check(n < 1000, 1);
	endtask : send
	task automatic wait_idle();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 3000) begin
			n++;
			@(posedge clk_sys);
		end
		check(n < 3000, 1);
	endtask : wait_idle
	task automatic run_write(logic [9:0] cyl, logic adj, int hold);
		@(posedge clk_sys);
		cylinder <= cyl;
		adjacent <= adj;
		i_drive.rises.delete();
		@(posedge clk_sys);
		start_write <= 1'b1;
		@(posedge clk_sys);
		start_write <= 1'b0;
		repeat (hold) @(posedge clk_sys);
		for (int k = 0; k < 4; k++)
			send(PAYLOAD[k], k == 3);
		s_valid <= 1'b0;
		wait_idle();
		check(gap3_min, (7 * 2 * (mfmw_pkg::ST_PPM + mfmw_pkg::WOT_PPM)
			+ mfmw_pkg::PPM - 1) / mfmw_pkg::PPM
			+ (adj ? mfmw_pkg::ADJ_EXTRA_BYTES : 0));
	endtask : run_write
	function automatic int first_odd(int q[$]);
		for (int i = 0; i + 1 < q.size(); i++)
			if (q[i+1] - q[i] != mfmw_pkg::CELL_CYC)
				return i;
		return 0;
	endfunction : first_odd
	// compares pulse spacing only, so the free running cell phase is moot
	task automatic check_pulses(logic pc);
		int bits[$];
		int ep[$];
		int ke, kr, sh, s4, s3, s2, s1;
		repeat (8) bits.push_back(0);
		foreach (PAYLOAD[k])
			for (int j = 7; j >= 0; j--)
				bits.push_back(PAYLOAD[k][j]);
		repeat (24) bits.push_back(0);
		for (int i = 2; i + 1 < bits.size(); i++) begin
			s4 = bits[i-2];
			s3 = bits[i-1];
			s2 = bits[i];
			s1 = bits[i+1];
			sh = 0;
			if (s2 == 1) begin
				if (pc && s3 == 0 && s1 == 1)
					sh = mfmw_pkg::PRECOMP_CYC;
				if (pc && s3 == 1 && s1 == 0)
					sh = -mfmw_pkg::PRECOMP_CYC;
				ep.push_back(i * 20 + mfmw_pkg::DATA_SLOT + sh);
			end else if (s3 == 0) begin // st3 alone writes nothing
				if (pc && s1 == 1 && s4 == 0)
					sh = -mfmw_pkg::PRECOMP_CYC;
				if (pc && s4 == 1 && s1 == 0)
					sh = mfmw_pkg::PRECOMP_CYC;
				ep.push_back(i * 20 + mfmw_pkg::CLK_SLOT + sh);
			end
		end
		ke = first_odd(ep);
		kr = first_odd(i_drive.rises);
		check(i_drive.rises.size() > kr + 36, 1);
		for (int m = 0; m < 36 && kr + m + 1 < i_drive.rises.size(); m++)
			check(i_drive.rises[kr+m+1] - i_drive.rises[kr+m],
				ep[ke+m+1] - ep[ke+m]);
	endtask : check_pulses
	// ----
	// scenarios
	// ----
	task automatic test_underrun();
		run_write(10'd401, 1'b0, 400);
		check(underrun, 1);
		$display("test underrun done");
	endtask : test_underrun
	task automatic test_precomp_on();
		run_write(10'd401, 1'b0, 0);
		check(underrun, 0);
		check_pulses(1'b1);
		$display("test precomp on done");
	endtask : test_precomp_on
	task automatic test_precomp_off();
		run_write(10'd400, 1'b1, 0);
		check_pulses(1'b0);
		$display("test precomp off done");
	endtask : test_precomp_off
	task automatic test_format();
		int n, d;
		@(posedge clk_sys);
		start_format <= 1'b1;
		s_data <= 8'hA5;
		s_last <= 1'b0;
		s_valid <= 1'b1;
		@(posedge clk_sys);
		start_format <= 1'b0;
		n = 0;
		while (write_gate_n !== 1'b0 && n < 2 * PERIOD) begin
			n++;
			@(posedge clk_sys);
		end
		d = 0;
		while (write_gate_n !== 1'b1 && d < 2 * PERIOD) begin
			d++;
			@(posedge clk_sys);
		end
		check(d >= PERIOD - 2 && d <= PERIOD + 2, 1);
		s_valid <= 1'b0;
		wait_idle();
		check(fmt_over, 0);
		$display("test format done");
	endtask : test_format
	// ----
	// run control
	// ----
	task automatic print_verdict();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : print_verdict
	// free running system clock
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// the whole sequence needs about 12000 cycles
	initial begin
		repeat (100000) @(posedge clk_sys);
		num_errors++;
		print_verdict();
	end
	// main sequence
	initial begin
		nrst = 1'b0;
		start_write = 1'b0;
		start_format = 1'b0;
		cylinder = 10'h000;
		adjacent = 1'b0;
		s_data = 8'h00;
		s_last = 1'b0;
		s_valid = 1'b0;
		num_errors = 0;
		num_checks = 0;
		repeat (20) @(posedge clk_sys);
		nrst <= 1'b1;
		test_underrun();
		test_precomp_on();
		test_precomp_off();
		test_format();
		print_verdict();
	end
endmodule : tb

//--- hdl/mfmw_cell_timer.sv
`timescale 1ns/100ps
module mfmw_cell_timer #(
	parameter int CELL = mfmw_pkg::CELL_CYC
) (
	input wire logic clk_sys,
	input wire logic nrst,
	output logic cell_start,
	output logic [mfmw_pkg::POS_W-1:0] pos
);

	// ----------------------------------------------------------------
	// bit cell divider
	// ----------------------------------------------------------------
	localparam logic [mfmw_pkg::POS_W-1:0] LAST =
		mfmw_pkg::POS_W'(CELL - 1);

	// free running so the cell phase never jumps mid write
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pos <= '0;
			cell_start <= 1'b0;
		end else begin
			cell_start <= (pos == LAST - 1'b1);
			if (pos == LAST) begin
				pos <= '0;
			end else begin
				pos <= pos + 1'b1;
			end
		end
	end

endmodule : mfmw_cell_timer

//--- hdl/mfmw_pkg.sv
package mfmw_pkg;

	// ----------------------------------------------------------------
	// clock and bit cell timing
	// ----------------------------------------------------------------
	localparam int CLK_KHZ = 100000;
	localparam int CLK_PERIOD_NS = 10;
	localparam int BIT_RATE_KBPS = 5000;
	localparam int CELL_CYC = CLK_KHZ / BIT_RATE_KBPS;
	localparam int POS_W = 5;
	localparam int PRECOMP_NS = 12;
	localparam int PRECOMP_CYC =
		(PRECOMP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PULSE_NS = 40;
	localparam int PULSE_CYC = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// nominal pulse positions inside a cell, leaving room for early moves
	localparam logic [4:0] CLK_SLOT = 5'h03;
	localparam logic [4:0] DATA_SLOT = 5'h0D;

	// ----------------------------------------------------------------
	// format figures
	// ----------------------------------------------------------------
	localparam logic [9:0] PRECOMP_CYL = 10'h190;
	localparam logic [7:0] POSTAMBLE_BYTE = 8'h00;
	localparam logic [7:0] FILL_BYTE = 8'h4E;
	localparam logic [1:0] POSTAMBLE_BYTES = 2'h3;
	localparam logic [1:0] PIPE_CELLS = 2'h3;
	localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
	localparam int TRACK_BYTES = 10416;
	localparam int ST_PPM = 5000;
	localparam int WOT_PPM = 1000;
	localparam int INDEX_TOL_BYTES = 1;
	localparam int PPM = 1000000;
	localparam int ADJ_EXTRA_BYTES = 5;
	localparam int GAP4_BYTES =
		(TRACK_BYTES * (ST_PPM + WOT_PPM) + PPM - 1) / PPM
		+ 2 * INDEX_TOL_BYTES;
	localparam logic [13:0] USABLE_BYTES = 14'(TRACK_BYTES - GAP4_BYTES);

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MFMW_NONE = 2'b00,
		MFMW_CLOCK = 2'b01,
		MFMW_DATA = 2'b10
	} mfmw_kind_t;

	typedef enum logic [1:0] {
		MFMW_ON_TIME = 2'b00,
		MFMW_EARLY = 2'b01,
		MFMW_LATE = 2'b10
	} mfmw_when_t;

	typedef struct packed {
		mfmw_kind_t kind;
		mfmw_when_t when;
	} mfmw_dec_t;

	typedef struct packed {
		logic [7:0] data;
		logic last;
	} mfmw_byte_t;

	typedef enum logic [2:0] {
		MFMW_IDLE = 3'b000,
		MFMW_ARM = 3'b001,
		MFMW_RUN = 3'b010,
		MFMW_POST = 3'b011,
		MFMW_FLUSH = 3'b100
	} mfmw_state_t;

endpackage : mfmw_pkg

//--- hdl/mfmw_write_path.sv
`timescale 1ns/100ps
// Function
// - three postamble bytes before write gate drops
// - gap three covers twice update times tolerance
// - adjacent sectors add five gap bytes
// - format runs index to next index
// - end gap is track tolerance plus index
// - sectors fit within track minus end gap
// - shift pulses against their predicted drift
// - displacement is twelve ns, rounded up to two cycles (20 ns), both ways
// - precompensate only above cylinder 400
// - outgoing bits pass a four stage register
// - cell spans stage three to stage four
// - decide at stage two, emit from three
// - zeros at three and two give clock
// - one at three, zero at two: nothing
// - one at stage two gives data pulse
// - pulses follow MFM rules with timing shift
// - whole track recorded in MFM
module mfmw_write_path (
	input wire logic CLK_SYS,
	input wire logic NRST,
	input wire logic START_WRITE,
	input wire logic START_FORMAT,
	input wire logic [9:0] CYLINDER,
	input wire logic ADJACENT,
	input wire logic INDEX_N,
	input wire logic [7:0] S_DATA,
	input wire logic S_LAST,
	input wire logic S_VALID,
	output logic S_READY,
	output logic WRITE_GATE_N,
	output logic WRITE_DATA,
	output logic BUSY,
	output logic UNDERRUN,
	output logic FMT_OVER,
	output logic [7:0] GAP3_MIN
);

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	// pulse choice for the bit in stage two; s = {st4, st3, st2, st1}
	function automatic mfmw_pkg::mfmw_dec_t decode(
		input logic [3:0] s,
		input logic pc_en
	);
		mfmw_pkg::mfmw_dec_t d;
		d.kind = mfmw_pkg::MFMW_NONE;
		d.when = mfmw_pkg::MFMW_ON_TIME;
		if (s[1]) begin
			d.kind = mfmw_pkg::MFMW_DATA;
			if (!s[2] && s[0]) begin
				d.when = mfmw_pkg::MFMW_LATE;
			end else if (s[2] && !s[0]) begin
				d.when = mfmw_pkg::MFMW_EARLY;
			end
		end else if (!s[2]) begin
			d.kind = mfmw_pkg::MFMW_CLOCK;
			if (s[3] != s[0]) begin
				d.when = s[0] ? mfmw_pkg::MFMW_EARLY : mfmw_pkg::MFMW_LATE;
			end
		end
		// stage three set, stage two clear: no pulse at all
		if (!pc_en) begin
			d.when = mfmw_pkg::MFMW_ON_TIME;
		end
		decode = d;
	endfunction : decode

	// first cell offset of the pulse, shifted by the precomp amount
	function automatic logic [4:0] slot_of(input mfmw_pkg::mfmw_dec_t d);
		logic [4:0] base;
		base = (d.kind == mfmw_pkg::MFMW_DATA) ?
			mfmw_pkg::DATA_SLOT : mfmw_pkg::CLK_SLOT;
		case (d.when)
			mfmw_pkg::MFMW_EARLY: begin
				slot_of = base - 5'(mfmw_pkg::PRECOMP_CYC);
			end
			mfmw_pkg::MFMW_LATE: begin
				slot_of = base + 5'(mfmw_pkg::PRECOMP_CYC);
			end
			default: begin
				slot_of = base;
			end
		endcase
	endfunction : slot_of

	// least tolerance gap after a sector update of n bytes
	function automatic logic [7:0] gap3_of(
		input logic [13:0] n,
		input logic adj
	);
		logic [31:0] t;
		t = (32'(n) * 32'(2 * (mfmw_pkg::ST_PPM + mfmw_pkg::WOT_PPM))
			+ 32'(mfmw_pkg::PPM - 1)) / 32'(mfmw_pkg::PPM);
		if (adj) begin
			t = t + 32'(mfmw_pkg::ADJ_EXTRA_BYTES);
		end
		gap3_of = t[7:0];
	endfunction : gap3_of

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	mfmw_pkg::mfmw_state_t state_q;
	mfmw_pkg::mfmw_dec_t dec_q;
	mfmw_pkg::mfmw_byte_t hold_q;
	logic cell_start;
	logic [mfmw_pkg::POS_W-1:0] pos;
	logic fmt_q;
	logic pc_en_q;
	logic idx_q;
	logic idx_edge;
	logic hold_full_q;
	logic ready_q;
	logic take;
	logic last_pend_q;
	logic last_taken_q;
	logic [3:0] sr_q;
	logic [7:0] out_q;
	logic [2:0] bit_cnt_q;
	logic [1:0] cnt_q;
	logic [13:0] n_q;
	logic budget_out;
	logic byte_edge;
	logic new_bit;
	logic [7:0] next_byte;
	logic [4:0] slot;
	logic gate_q;
	logic pulse_q;
	logic under_q;
	logic over_q;
	logic [7:0] gap3_q;

	// ----------------------------------------------------------------
	// cell timing
	// ----------------------------------------------------------------
	mfmw_cell_timer #(
		.CELL(mfmw_pkg::CELL_CYC)
	) u_timer (
		.clk_sys(CLK_SYS),
		.nrst(NRST),
		.cell_start(cell_start),
		.pos(pos)
	);

	// ----------------------------------------------------------------
	// byte intake
	// ----------------------------------------------------------------
	assign take = S_VALID && ready_q;
	assign idx_edge = !INDEX_N && !idx_q;
	// usable area ends where the end-of-track gap begins
	assign budget_out = fmt_q && (n_q >= mfmw_pkg::USABLE_BYTES);
	assign byte_edge = cell_start && (bit_cnt_q == 3'h0);

	// index level history for edge detection
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			idx_q <= 1'b0;
		end else begin
			idx_q <= !INDEX_N;
		end
	end

	// one byte of holding; ready is registered so it can lead the take
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			hold_q <= '0;
			hold_full_q <= 1'b0;
			ready_q <= 1'b0;
			last_taken_q <= 1'b0;
		end else begin
			if (state_q == mfmw_pkg::MFMW_IDLE) begin
				hold_full_q <= 1'b0;
				last_taken_q <= 1'b0;
			end else if (take) begin
				hold_q <= '{data: S_DATA, last: S_LAST && !fmt_q};
				hold_full_q <= 1'b1;
				last_taken_q <= S_LAST && !fmt_q;
			end else if (byte_edge && state_q == mfmw_pkg::MFMW_RUN
				&& !last_pend_q) begin
				hold_full_q <= 1'b0;
			end
			ready_q <= (state_q == mfmw_pkg::MFMW_RUN
				|| state_q == mfmw_pkg::MFMW_ARM)
				&& !hold_full_q && !take && !ready_q
				&& !last_taken_q && !budget_out;
		end
	end

	// ----------------------------------------------------------------
	// serialiser
	// ----------------------------------------------------------------
	// byte to start when the previous one is exhausted
	always_comb begin
		next_byte = mfmw_pkg::FILL_BYTE;
		if (state_q == mfmw_pkg::MFMW_POST || last_pend_q) begin
			next_byte = mfmw_pkg::POSTAMBLE_BYTE;
		end else if (hold_full_q) begin
			next_byte = hold_q.data;
		end
		if (state_q == mfmw_pkg::MFMW_FLUSH) begin
			next_byte = 8'h00;
		end
	end

	assign new_bit = (bit_cnt_q == 3'h0) ? next_byte[7] : out_q[7];

	// bits leave msb first, one per cell
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			out_q <= 8'h00;
			bit_cnt_q <= 3'h0;
		end else if (state_q == mfmw_pkg::MFMW_IDLE
			|| state_q == mfmw_pkg::MFMW_ARM) begin
			bit_cnt_q <= 3'h0;
		end else if (cell_start) begin
			if (bit_cnt_q == 3'h0) begin
				out_q <= {next_byte[6:0], 1'b0};
				bit_cnt_q <= mfmw_pkg::BYTE_LAST_BIT;
			end else begin
				out_q <= {out_q[6:0], 1'b0};
				bit_cnt_q <= bit_cnt_q - 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// write sequencer
	// ----------------------------------------------------------------
	// a data write ends by its own last byte; a format ends on index
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			state_q <= mfmw_pkg::MFMW_IDLE;
			fmt_q <= 1'b0;
			pc_en_q <= 1'b0;
			gate_q <= 1'b0;
			last_pend_q <= 1'b0;
			cnt_q <= 2'h0;
			n_q <= 14'h0000;
		end else begin
			case (state_q)
				mfmw_pkg::MFMW_IDLE: begin
					last_pend_q <= 1'b0;
					// cylinder is latched per operation
					pc_en_q <= CYLINDER > mfmw_pkg::PRECOMP_CYL;
					n_q <= 14'h0000;
					if (START_FORMAT) begin
						fmt_q <= 1'b1;
						state_q <= mfmw_pkg::MFMW_ARM;
					end else if (START_WRITE) begin
						fmt_q <= 1'b0;
						gate_q <= 1'b1;
						state_q <= mfmw_pkg::MFMW_RUN;
					end
				end
				mfmw_pkg::MFMW_ARM: begin
					if (idx_edge) begin
						gate_q <= 1'b1;
						state_q <= mfmw_pkg::MFMW_RUN;
					end
				end
				mfmw_pkg::MFMW_RUN: begin
					if (fmt_q && idx_edge) begin
						gate_q <= 1'b0;
						state_q <= mfmw_pkg::MFMW_IDLE;
					end else if (byte_edge) begin
						if (last_pend_q) begin
							// first postamble byte starts here
							cnt_q <= mfmw_pkg::POSTAMBLE_BYTES - 2'h1;
							n_q <= n_q + 14'h0001;
							state_q <= mfmw_pkg::MFMW_POST;
						end else if (hold_full_q) begin
							n_q <= n_q + 14'h0001;
							last_pend_q <= hold_q.last;
						end
					end
				end
				mfmw_pkg::MFMW_POST: begin
					if (byte_edge) begin
						if (cnt_q != 2'h0) begin
							cnt_q <= cnt_q - 2'h1;
							n_q <= n_q + 14'h0001;
						end else begin
							cnt_q <= mfmw_pkg::PIPE_CELLS;
							state_q <= mfmw_pkg::MFMW_FLUSH;
						end
					end
				end
				mfmw_pkg::MFMW_FLUSH: begin
					// drain the last postamble bit out of stage three
					if (cell_start) begin
						if (cnt_q == 2'h0) begin
							gate_q <= 1'b0;
							state_q <= mfmw_pkg::MFMW_IDLE;
						end else begin
							cnt_q <= cnt_q - 2'h1;
						end
					end
				end
				default: begin
					gate_q <= 1'b0;
					state_q <= mfmw_pkg::MFMW_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// precompensation window
	// ----------------------------------------------------------------
	// decide for stage two, then shift so that bit lands in stage three
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			sr_q <= 4'h0;
			dec_q <= '{kind: mfmw_pkg::MFMW_NONE,
				when: mfmw_pkg::MFMW_ON_TIME};
		end else if (!gate_q) begin
			sr_q <= 4'h0;
			dec_q <= '{kind: mfmw_pkg::MFMW_NONE,
				when: mfmw_pkg::MFMW_ON_TIME};
		end else if (cell_start) begin
			dec_q <= decode(sr_q, pc_en_q);
			sr_q <= {sr_q[2:0], new_bit};
		end
	end

	assign slot = slot_of(dec_q);

	// pulse lives inside the cell that opened at the shift
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			pulse_q <= 1'b0;
		end else begin
			pulse_q <= gate_q && dec_q.kind != mfmw_pkg::MFMW_NONE
				&& pos >= slot
				&& pos < slot + 5'(mfmw_pkg::PULSE_CYC);
		end
	end

	// ----------------------------------------------------------------
	// status
	// ----------------------------------------------------------------
	// flags clear on the next start; a new event in that cycle wins
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			under_q <= 1'b0;
			over_q <= 1'b0;
			gap3_q <= 8'h00;
		end else begin
			if (byte_edge && state_q == mfmw_pkg::MFMW_RUN && !fmt_q
				&& !hold_full_q && !last_pend_q) begin
				under_q <= 1'b1;
			end else if (START_WRITE || START_FORMAT) begin
				under_q <= 1'b0;
			end
			if (budget_out && S_VALID) begin
				over_q <= 1'b1;
			end else if (START_WRITE || START_FORMAT) begin
				over_q <= 1'b0;
			end
			if (state_q == mfmw_pkg::MFMW_FLUSH && !fmt_q) begin
				gap3_q <= gap3_of(n_q, ADJACENT);
			end
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			WRITE_GATE_N <= 1'b1;
			BUSY <= 1'b0;
		end else begin
			WRITE_GATE_N <= !gate_q;
			BUSY <= state_q != mfmw_pkg::MFMW_IDLE;
		end
	end

	assign S_READY = ready_q;
	assign WRITE_DATA = pulse_q;
	assign UNDERRUN = under_q;
	assign FMT_OVER = over_q;
	assign GAP3_MIN = gap3_q;

endmodule : mfmw_write_path
